// ==== inc/dtc_pkg.sv ====
package dtc_pkg;
    // Array geometry
    localparam int VENTRIES = 8;
    localparam int FSETS = 128;
    localparam int FWAYS = 4;
    localparam int IDXW = 10;
    localparam int VIDXW = 3;
    localparam int WAYW = 2;
    localparam int SETW = 7;
    localparam int TOTAL = VENTRIES + FSETS * FWAYS;
    // Register byte offsets
    localparam logic [7:0] OFS_INDEX = 8'h00;
    localparam logic [7:0] OFS_RANDOM = 8'h04;
    localparam logic [7:0] OFS_WIRED = 8'h08;
    localparam logic [7:0] OFS_PAGE_SIZE_MASK_REG = 8'h0c;
    localparam logic [7:0] OFS_ENTRY_HIGH_REG = 8'h10;
    localparam logic [7:0] OFS_ENTRYLO = 8'h14;
    localparam logic [7:0] OFS_CONFIG = 8'h18;
    localparam logic [7:0] OFS_COMMAND = 8'h1c;
    localparam logic [7:0] OFS_PGCTRL = 8'h20;
    // Field positions
    localparam int RANDOM_WAY_FIELD_POS = 16;
    localparam int PROBE_MISS_POS = 31;
    localparam int CFG_VSIZE_POS = 0;
    localparam int CFG_WAYS_POS = 8;
    localparam int CFG_SETS_POS = 16;
    localparam int EH_VPN_POS = 13;
    localparam int EH_INV_POS = 10;
    localparam int PM_LOW_POS = 11;
    localparam logic [15:0] FIXED_PAGE_MASK = 16'h0000;
    // Commands
    localparam logic [1:0] CMD_PROBE = 2'h0;
    localparam logic [1:0] CMD_WRITE_INDEXED = 2'h1;
    localparam logic [1:0] CMD_WRITE_RANDOM = 2'h2;
    localparam logic [1:0] CMD_READ = 2'h3;
    // Reset values
    localparam logic [VIDXW-1:0] RANDOM_RESET = 3'h7;
    localparam logic [IDXW-1:0] INDEX_RESET = 10'h000;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_RESP = 3'b010,
        ST_RDATA = 3'b100
    } dtc_bus_type;
endpackage

// ==== src/dtc_fixed_array.sv ====
module dtc_fixed_array
    import dtc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic writeEn,
    input wire logic [SETW-1:0] writeSet,
    input wire logic [WAYW-1:0] writeWay,
    input wire logic [18:0] writeVpn,
    input wire logic writeInv,
    input wire logic [31:0] writeLow,
    input wire logic [SETW-1:0] lookSet,
    input wire logic [18:0] lookVpn,
    input wire logic [WAYW-1:0] readWay,
    output logic hit,
    output logic [WAYW-1:0] hitWay,
    output logic [31:0] readLow,
    output logic [18:0] readVpn,
    output logic readInv
);
    logic [18:0] vpn [FSETS*FWAYS];
    logic [31:0] low [FSETS*FWAYS];
    logic inv [FSETS*FWAYS];
    logic [18:0] next_vpn;
    logic [31:0] next_low;
    logic next_inv;
    logic [8:0] wAddr;

    // Entry storage with per-entry hardware invalidate bit
    assign wAddr = {writeSet, writeWay};
    always_comb begin
        next_vpn = writeVpn;
        next_low = writeLow;
        next_inv = writeInv;
    end
    always_ff @(posedge clk) begin
        for (int i = 0; i < FSETS * FWAYS; i++) begin
            if (reset) begin
                inv[i] <= 1'b1;
                vpn[i] <= '0;
                low[i] <= '0;
            end else if (writeEn && wAddr == 9'(i)) begin
                inv[i] <= next_inv;
                vpn[i] <= next_vpn;
                low[i] <= next_low;
            end
        end
    end

    // Parallel way compare within the indexed set; invalid entries never hit
    always_comb begin
        hit = 1'b0;
        hitWay = '0;
        for (int w = 0; w < FWAYS; w++) begin
            if (!inv[{lookSet, WAYW'(w)}] && vpn[{lookSet, WAYW'(w)}] == lookVpn) begin
                hit = 1'b1;
                hitWay = WAYW'(w);
            end
        end
    end
    assign readLow = low[{writeSet, readWay}];
    assign readVpn = vpn[{writeSet, readWay}];
    assign readInv = inv[{writeSet, readWay}];
endmodule // dtc_fixed_array

// ==== src/dtc_top.sv ====
// Functional notes
// - Fixed-array index encodes set and way
// - Probe loads index register with match
// - Size field reports variable array only
// - Only variable-array entries may be wired
// - Random fixed-size write never hits wired
// - Fixed array has per-entry invalidate bit
// - Mask bits 12:11 zero unless 1K enabled
// - Low indices variable array, higher fixed
// - Wired value limited to variable count minus one
// - Other page size random write uses random field
//
// Local design decisions: the register offsets and the AXI4-Lite interface to the registers.
module dtc_top
    import dtc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    function automatic logic is_mapped(input logic [7:0] a);
        if (a == OFS_INDEX) return 1'b1;
        else if (a == OFS_RANDOM) return 1'b1;
        else if (a == OFS_WIRED) return 1'b1;
        else if (a == OFS_PAGE_SIZE_MASK_REG) return 1'b1;
        else if (a == OFS_ENTRY_HIGH_REG) return 1'b1;
        else if (a == OFS_ENTRYLO) return 1'b1;
        else if (a == OFS_CONFIG) return 1'b1;
        else if (a == OFS_COMMAND) return 1'b1;
        else if (a == OFS_PGCTRL) return 1'b1;
        else return 1'b0;
    endfunction

    dtc_bus_type wState, next_wState, rState, next_rState;
    logic awHeld, wHeld, next_awHeld, next_wHeld;
    logic [7:0] awAddr, next_awAddr;
    logic [31:0] wData, next_wData;
    logic [1:0] bResp, next_bResp, rResp, next_rResp;
    logic [31:0] rData, next_rData;
    logic [IDXW-1:0] entryIndex, next_entryIndex;
    logic probeMiss, next_probeMiss;
    logic [VIDXW-1:0] randomSel, next_randomSel;
    logic [WAYW-1:0] random_way_field, next_random_way_field;
    logic [VIDXW-1:0] wired, next_wired;
    logic [17:0] page_size_mask_reg, next_page_size_mask_reg;
    logic [31:0] entryHigh, next_entryHigh;
    logic [31:0] entryLow, next_entryLow;
    logic en1k, next_en1k;
    logic [18:0] vVpn [VENTRIES];
    logic [31:0] vLow [VENTRIES];
    logic vWrite;
    logic [VIDXW-1:0] vAddr;
    logic fHit;
    logic [WAYW-1:0] fHitWay, fWay;
    logic [SETW-1:0] fSet;
    logic [31:0] fLow;
    logic [18:0] fVpn;
    logic fInv;
    logic doCmd;
    logic [1:0] cmd;
    logic [IDXW-1:0] fRel;

    // Write channel: accept address and data in either order
    always_comb begin
        next_wState = wState;
        next_awHeld = awHeld;
        next_wHeld = wHeld;
        next_awAddr = awAddr;
        next_wData = wData;
        next_bResp = bResp;
        doCmd = 1'b0;
        case (wState)
            ST_IDLE: begin
                if (s_axi_awvalid && s_axi_awready && !awHeld) begin
                    next_awHeld = 1'b1;
                    next_awAddr = s_axi_awaddr;
                end
                if (s_axi_wvalid && s_axi_wready && !wHeld) begin
                    next_wHeld = 1'b1;
                    next_wData = s_axi_wdata;
                end
                if (next_awHeld && next_wHeld) begin
                    next_wState = ST_RESP;
                    next_bResp = is_mapped(next_awAddr) ? 2'h0 : 2'h2;
                end
            end
            ST_RESP: begin
                if (s_axi_bready) begin
                    next_wState = ST_IDLE;
                    next_awHeld = 1'b0;
                    next_wHeld = 1'b0;
                end
            end
            default: next_wState = ST_IDLE;
        endcase
        if (wState == ST_RESP && s_axi_bready && awAddr == OFS_COMMAND) doCmd = 1'b1;
    end
    assign cmd = wData[1:0];
    always_ff @(posedge clk) begin
        if (reset) begin
            wState <= ST_IDLE;
            awHeld <= 1'b0;
            wHeld <= 1'b0;
            awAddr <= '0;
            wData <= '0;
            bResp <= '0;
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= '0;
        end else begin
            wState <= next_wState;
            awHeld <= next_awHeld;
            wHeld <= next_wHeld;
            awAddr <= next_awAddr;
            wData <= next_wData;
            bResp <= next_bResp;
            s_axi_awready <= next_wState == ST_IDLE && !next_awHeld;
            s_axi_wready <= next_wState == ST_IDLE && !next_wHeld;
            s_axi_bvalid <= next_wState == ST_RESP;
            s_axi_bresp <= next_bResp;
        end
    end

    // Fixed-array location from index (set in upper bits, way in lower bits); probe and random write take the set from EntryHigh
    assign fRel = entryIndex - IDXW'(VENTRIES);
    assign fSet = (cmd == CMD_WRITE_RANDOM) ? entryHigh[EH_VPN_POS +: SETW]
                : (cmd == CMD_PROBE) ? entryHigh[EH_VPN_POS +: SETW]
                : fRel[WAYW +: SETW];
    assign fWay = (cmd == CMD_WRITE_RANDOM) ? random_way_field : fRel[WAYW-1:0];

    // Command decode and register updates
    always_comb begin
        next_entryIndex = entryIndex;
        next_probeMiss = probeMiss;
        next_wired = wired;
        next_page_size_mask_reg = page_size_mask_reg;
        next_entryHigh = entryHigh;
        next_entryLow = entryLow;
        next_en1k = en1k;
        next_random_way_field = random_way_field + 2'h1;
        // Random field cycles from top down to wired boundary
        next_randomSel = (randomSel <= wired) ? RANDOM_RESET : randomSel - 3'h1;
        vWrite = 1'b0;
        vAddr = randomSel;
        if (wState == ST_RESP && s_axi_bready) begin
            if (awAddr == OFS_INDEX) next_entryIndex = wData[IDXW-1:0];
            else if (awAddr == OFS_WIRED) begin
                next_wired = wData[VIDXW-1:0];
                next_randomSel = RANDOM_RESET;
            end else if (awAddr == OFS_PAGE_SIZE_MASK_REG) next_page_size_mask_reg = wData[PM_LOW_POS +: 18];
            else if (awAddr == OFS_ENTRY_HIGH_REG) next_entryHigh = wData;
            else if (awAddr == OFS_ENTRYLO) next_entryLow = wData;
            else if (awAddr == OFS_PGCTRL) next_en1k = wData[0];
        end
        if (!next_en1k) next_page_size_mask_reg[1:0] = 2'h0;
        if (doCmd) begin
            case (cmd)
                CMD_PROBE: begin
                    next_probeMiss = 1'b1;
                    if (fHit) begin
                        next_probeMiss = 1'b0;
                        next_entryIndex = IDXW'(VENTRIES) + {fSet, fHitWay};
                    end
                    for (int i = 0; i < VENTRIES; i++) begin
                        if (vVpn[i] == entryHigh[31:13]) begin
                            next_probeMiss = 1'b0;
                            next_entryIndex = IDXW'(i);
                        end
                    end
                end
                CMD_WRITE_INDEXED: begin
                    vWrite = entryIndex < IDXW'(VENTRIES);
                    vAddr = entryIndex[VIDXW-1:0];
                end
                CMD_WRITE_RANDOM: begin
                    // Fixed-size pages go to the fixed array, away from wired entries
                    vWrite = page_size_mask_reg != {FIXED_PAGE_MASK, 2'h0};
                    vAddr = randomSel;
                end
                default: begin
                    if (entryIndex < IDXW'(VENTRIES)) begin
                        next_entryHigh = {vVpn[entryIndex[VIDXW-1:0]], 13'h0000};
                        next_entryLow = vLow[entryIndex[VIDXW-1:0]];
                    end else begin
                        next_entryHigh = {fVpn, 2'h0, fInv, 10'h000};
                        next_entryLow = fLow;
                    end
                end
            endcase
        end
    end
    wire fixedWr = doCmd && ((cmd == CMD_WRITE_INDEXED && entryIndex >= IDXW'(VENTRIES)
        && entryIndex < IDXW'(TOTAL)) || (cmd == CMD_WRITE_RANDOM
        && page_size_mask_reg == {FIXED_PAGE_MASK, 2'h0}));

    always_ff @(posedge clk) begin
        if (reset) begin
            entryIndex <= INDEX_RESET;
            probeMiss <= 1'b0;
            randomSel <= RANDOM_RESET;
            random_way_field <= '0;
            wired <= '0;
            page_size_mask_reg <= '0;
            entryHigh <= '0;
            entryLow <= '0;
            en1k <= 1'b0;
        end else begin
            entryIndex <= next_entryIndex;
            probeMiss <= next_probeMiss;
            randomSel <= next_randomSel;
            random_way_field <= next_random_way_field;
            wired <= next_wired;
            page_size_mask_reg <= next_page_size_mask_reg;
            entryHigh <= next_entryHigh;
            entryLow <= next_entryLow;
            en1k <= next_en1k;
        end
    end

    // Variable-size array storage
    always_ff @(posedge clk) begin
        for (int i = 0; i < VENTRIES; i++) begin
            if (reset) begin
                vVpn[i] <= 19'h7ffff;
                vLow[i] <= '0;
            end else if (vWrite && vAddr == VIDXW'(i)) begin
                vVpn[i] <= entryHigh[31:13];
                vLow[i] <= entryLow;
            end
        end
    end

    dtc_fixed_array u_fixed (
        .clk(clk),
        .reset(reset),
        .writeEn(fixedWr),
        .writeSet(fSet),
        .writeWay(fWay),
        .writeVpn(entryHigh[31:13]),
        .writeInv(entryHigh[EH_INV_POS]),
        .writeLow(entryLow),
        .lookSet(entryHigh[EH_VPN_POS +: SETW]),
        .lookVpn(entryHigh[31:13]),
        .readWay(fWay),
        .hit(fHit),
        .hitWay(fHitWay),
        .readLow(fLow),
        .readVpn(fVpn),
        .readInv(fInv)
    );

    // Read channel with register readback
    always_comb begin
        next_rState = rState;
        next_rData = rData;
        next_rResp = rResp;
        case (rState)
            ST_IDLE: begin
                if (s_axi_arvalid && s_axi_arready) begin
                    next_rState = ST_RDATA;
                    next_rResp = is_mapped(s_axi_araddr) ? 2'h0 : 2'h2;
                    next_rData = '0;
                    if (s_axi_araddr == OFS_INDEX)
                        next_rData = {probeMiss, 21'h0, entryIndex};
                    else if (s_axi_araddr == OFS_RANDOM)
                        next_rData = {14'h0, random_way_field, 13'h0, randomSel};
                    else if (s_axi_araddr == OFS_WIRED) next_rData = {29'h0, wired};
                    else if (s_axi_araddr == OFS_PAGE_SIZE_MASK_REG)
                        next_rData = {3'h0, page_size_mask_reg, 11'h0};
                    else if (s_axi_araddr == OFS_ENTRY_HIGH_REG) next_rData = entryHigh;
                    else if (s_axi_araddr == OFS_ENTRYLO) next_rData = entryLow;
                    else if (s_axi_araddr == OFS_CONFIG)
                        next_rData = {8'h0, 8'(SETW), 8'(FWAYS), 8'(VENTRIES - 1)};
                    else if (s_axi_araddr == OFS_PGCTRL) next_rData = {31'h0, en1k};
                end
            end
            ST_RDATA: if (s_axi_rready) next_rState = ST_IDLE;
            default: next_rState = ST_IDLE;
        endcase
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            rState <= ST_IDLE;
            rData <= '0;
            rResp <= '0;
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= '0;
            s_axi_rresp <= '0;
        end else begin
            rState <= next_rState;
            rData <= next_rData;
            rResp <= next_rResp;
            s_axi_arready <= next_rState == ST_IDLE;
            s_axi_rvalid <= next_rState == ST_RDATA;
            s_axi_rdata <= next_rData;
            s_axi_rresp <= next_rResp;
        end
    end
endmodule // dtc_top

// ==== tb/dtc_top_monitor.sv ====
module dtc_top_monitor
    import dtc_pkg::*;
(
    input wire logic clk,
    input wire logic reset,
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic [7:0] rdAddr, next_rdAddr, wrAddr, next_wrAddr;
    logic en1k, next_en1k;
    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);
    // Track read address, write address and the 1K page enable
    always_comb begin
        next_rdAddr = (s_axi_arvalid && s_axi_arready) ? s_axi_araddr : rdAddr;
        next_wrAddr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : wrAddr;
        next_en1k = en1k;
        if (s_axi_wvalid && s_axi_wready && next_wrAddr == OFS_PGCTRL) begin
            next_en1k = s_axi_wdata[0];
        end
    end
    always_ff @(posedge clk) begin
        if (reset) begin
            rdAddr <= 8'h00;
            wrAddr <= 8'h00;
            en1k <= 1'b0;
        end else begin
            rdAddr <= next_rdAddr;
            wrAddr <= next_wrAddr;
            en1k <= next_en1k;
        end
    end
    chk_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |=> s_axi_bvalid) else $error("write response late");
    chk_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    chk_read_holds: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    chk_config_sizes: assert property (s_axi_rvalid && rdAddr == OFS_CONFIG
        |-> s_axi_rdata == 32'h00070407) else $error("size fields wrong");
    chk_wired_bound: assert property (s_axi_rvalid && rdAddr == OFS_WIRED
        |-> s_axi_rdata[31:3] == 29'h0) else $error("wired above limit");
    chk_random_fields: assert property (s_axi_rvalid && rdAddr == OFS_RANDOM
        |-> s_axi_rdata[31:18] == 14'h0 && s_axi_rdata[15:3] == 13'h0)
        else $error("random fields wrong");
    chk_mask_gated: assert property (s_axi_rvalid && rdAddr == OFS_PAGE_SIZE_MASK_REG && !en1k
        |-> s_axi_rdata[12:11] == 2'h0) else $error("mask low bits set");
    chk_index_range: assert property (s_axi_rvalid && rdAddr == OFS_INDEX
        |-> s_axi_rdata[30:10] == 21'h0 && s_axi_rdata[9:0] < TOTAL)
        else $error("index out of range");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && rdAddr == OFS_INDEX && s_axi_rdata[31]);
    cover property (s_axi_rvalid && rdAddr == OFS_PAGE_SIZE_MASK_REG && en1k);
endmodule // dtc_top_monitor

// ==== tb/test_dtc_top.sv ====
module test_dtc_top
    import dtc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 0, reset = 1;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    logic [31:0] s_axi_wdata = 0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hf;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] d;
    int fails = 0, checked = 0;
    dtc_top dut (.clk, .reset, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
    // Clock at 50 MHz
    initial begin
        forever #10 clk = ~clk;
    end
    task automatic close_out();
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Count up a wait; past 50 cycles the spent bound ends the run
    task automatic tick(inout int n);
        @(posedge clk);
        n++;
        if (n > 50) begin
            fails++;
            close_out();
        end
    endtask
    // Bus write, held until each channel is taken
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er = 2'h0);
        int n = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        do begin
            tick(n);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
        end while (s_axi_bvalid !== 1'b1);
        chk({30'h0, s_axi_bresp}, {30'h0, er});
        s_axi_bready <= 0;
        @(posedge clk);
    endtask
    // Bus read, compared under a mask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
        input logic [1:0] er = 2'h0);
        int n = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        do begin
            tick(n);
            if (s_axi_arready) s_axi_arvalid <= 0;
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        chk({30'h0, s_axi_rresp}, {30'h0, er});
        chk(d & m, e);
        s_axi_rready <= 0;
        @(posedge clk);
    endtask
    function automatic logic [31:0] fidx(input int s, input int w);
        return 32'(VENTRIES + s * FWAYS + w);
    endfunction
    task automatic put(input logic [31:0] i, input logic [31:0] h, input logic [31:0] l,
        input logic [1:0] c);
        wr(OFS_ENTRY_HIGH_REG, h);
        wr(OFS_ENTRYLO, l);
        wr(OFS_INDEX, i);
        wr(OFS_COMMAND, {30'h0, c});
    endtask
    task automatic probe(input logic [31:0] h, input logic [31:0] m, input logic [31:0] e);
        wr(OFS_ENTRY_HIGH_REG, h);
        wr(OFS_COMMAND, {30'h0, CMD_PROBE});
        rc(OFS_INDEX, m, e);
    endtask
    // Main sequence
    initial begin
        repeat (12) @(posedge clk);
        reset <= 0;
        repeat (2) @(posedge clk);
        rc(OFS_CONFIG, 32'hffffffff, 32'h00070407);
        rc(OFS_PAGE_SIZE_MASK_REG, 32'h00001800, 0);
        rc(8'h24, 32'hffffffff, 0, 2'h2);
        wr(8'h24, 32'h1, 2'h2);
        wr(OFS_WIRED, 32'hf);
        rc(OFS_WIRED, 32'hfffffff8, 0);
        wr(OFS_WIRED, 32'h7);
        rc(OFS_WIRED, 32'hffffffff, 32'h7);
        wr(OFS_PAGE_SIZE_MASK_REG, 32'h1fffffff);
        rc(OFS_PAGE_SIZE_MASK_REG, 32'h00001800, 0);
        wr(OFS_PGCTRL, 32'h1);
        wr(OFS_PAGE_SIZE_MASK_REG, 32'h00001800);
        rc(OFS_PAGE_SIZE_MASK_REG, 32'h00001800, 32'h00001800);
        wr(OFS_PGCTRL, 32'h0);
        wr(OFS_PAGE_SIZE_MASK_REG, 32'h0);
        put(fidx(5, 2), 32'h0000a000, 32'h12345678, CMD_WRITE_INDEXED);
        put(32'h3, 32'h80000000, 32'h0000abcd, CMD_WRITE_INDEXED);
        probe(32'h0000a000, 32'h800003ff, fidx(5, 2));
        wr(OFS_ENTRYLO, 32'h0);
        wr(OFS_COMMAND, {30'h0, CMD_READ});
        rc(OFS_ENTRYLO, 32'hffffffff, 32'h12345678);
        probe(32'h80000000, 32'h800003ff, 32'h3);
        probe(32'h00fe0000, 32'h80000000, 32'h80000000);
        put(fidx(5, 2), 32'h0000a400, 32'h0, CMD_WRITE_INDEXED);
        probe(32'h0000a000, 32'h80000000, 32'h80000000);
        wr(OFS_PAGE_SIZE_MASK_REG, 32'h00006000);
        put(32'h0, 32'h40000000, 32'h0, CMD_WRITE_RANDOM);
        probe(32'h40000000, 32'h800003ff, 32'h7);
        wr(OFS_PAGE_SIZE_MASK_REG, 32'h0);
        put(32'h0, 32'h20012000, 32'h0, CMD_WRITE_RANDOM);
        probe(32'h20012000, 32'h800003fc, fidx(9, 0));
        probe(32'h40000000, 32'h800003ff, 32'h7);
        probe(32'h80000000, 32'h800003ff, 32'h3);
        rc(OFS_RANDOM, 32'h00000007, 32'h7);
        close_out();
    end
endmodule // test_dtc_top
bind dtc_top dtc_top_monitor mon (.clk(clk), .reset(reset), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready));
